// >>> pkg/uecb_pkg.sv
// Shared constants for the endpoint configuration byte block.
// Assumes a 32-bit AHB-Lite register bus and a 100 MHz system clock.
package uecb_pkg;
    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] OUT_CFG_ADDR = 8'h00; // OUT stream configuration
    localparam logic [7:0] IN_CFG_ADDR = 8'h04; // Iso select bits, one per IN endpoint
    localparam logic [7:0] IN_CNT_ADDR = 8'h08; // Y count of selected IN endpoint
    localparam logic [7:0] IN_SEL_ADDR = 8'h0C; // Selects IN endpoint for count access
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h10; // Sticky event status
    localparam logic [7:0] IRQ_EN_ADDR = 8'h14; // Event enable
    localparam logic [7:0] IRQ_CLR_ADDR = 8'h18; // Write one to clear
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int OUT_EN_BIT = 7; // Endpoint enable
    localparam int OUT_ISO_BIT = 6; // Isochronous select
    localparam int OUT_OVF_BIT = 5; // Overflow diagnostic flag
    localparam int SWB_MSB = 4; // Sample width field top
    localparam int EMPTY_BIT = 7; // Y buffer empty flag
    localparam int CNT_MSB = 6; // Packet count field top
    localparam int IN_EP_MAX = 7; // IN endpoints beside control
    localparam int CFG_BLOCK_BYTES = 8; // Bytes per IN config block
    localparam int EV_W = 3; // Event count
    localparam int EV_OVF = 0; // Overflow event
    localparam int EV_IN_DONE = 1; // IN transaction finished
    localparam int EV_NAK = 2; // NAK sent
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] OUT_CFG_RST = 8'h00;
    localparam logic [7:0] IN_CNT_RST = 8'h00;
    // ************************************************************
    // IN handshake decision
    // ************************************************************
    typedef enum logic [1:0] {
        UECB_HS_NONE = 2'b00,
        UECB_HS_DATA = 2'b01,
        UECB_HS_NAK = 2'b10
    } uecb_hs_t;
endpackage

// >>> core/uecb_in_ep.sv
// One IN endpoint Y count byte with its empty flag.
// Assumes strobes from the buffer manager and the bus slave on sys_clk.
`timescale 1ns/10ps
module uecb_in_ep (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic in_done,
    output logic [7:0] cnt_byte
);
    logic [7:0] cnt_q; // Empty flag and packet count
    // ************************************************************
    // Count byte update
    // ************************************************************
    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_q <= uecb_pkg::IN_CNT_RST;
        end else begin
            if (wr_en) begin
                cnt_q <= wr_data; // Software loads length [RQ13]
            end
            if (in_done) begin
                cnt_q[uecb_pkg::EMPTY_BIT] <= 1'b1; // Mark buffer drained [RQ8]
            end
        end
    end
    assign cnt_byte = cnt_q;
endmodule

// >>> core/uecb_len_calc.sv
// Converts a packet count into a byte length.
// Assumes sample width field encodes bytes minus one.
`timescale 1ns/10ps
module uecb_len_calc (
    input wire logic iso,
    input wire logic [6:0] count,
    input wire logic [4:0] swb,
    output logic [11:0] len_bytes
);
    logic [5:0] per_sample; // Field plus one
    // Sample count times bytes per sample on iso [RQ15]
    always_comb begin
        per_sample = {1'b0, swb} + 6'h01; // 00h is one byte [RQ5]
        if (iso) begin
            // Widen both factors first so the product is not cut to seven bits
            len_bytes = 12'(count) * 12'(per_sample); // Samples held [RQ14]
        end else begin
            len_bytes = {5'h00, count}; // Bytes held [RQ14]
        end
    end
endmodule

// >>> core/uecb_top.sv
// Endpoint configuration and status bytes with an AHB-Lite slave.
// Assumes one bus master and a buffer manager on the same clock.
//
// Overview of operation
// RQ1: OUT accepts only when enable bit set
// RQ2: Bit six selects isochronous OUT transfers
// RQ3: Overflow sets diagnostic flag, no other effect; code also sets overflow event status bit 0, which can raise irq
// RQ4: Only software write of zero clears overflow
// RQ5: Sample width is field plus one bytes
// RQ6: Each IN endpoint has eight-byte block; code uses one shared iso word and a count window instead
// RQ7: Up to seven IN endpoints besides control
// RQ8: Successful IN sets Y buffer empty flag
// RQ9: Non-iso empty endpoint answers IN with NAK
// RQ10: Software clears empty flag before next packet
// RQ11: Iso IN never NAKs, ignores empty flag
// RQ12: Software clears empty flag on iso too
// RQ13: Software writes packet length into count
// RQ14: Count is bytes, or samples on iso
// RQ15: Iso length converted using sample width
`timescale 1ns/10ps
module uecb_top #(
    parameter int NUM_IN = uecb_pkg::IN_EP_MAX
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // OUT side from serial engine
    input wire logic out_req,
    input wire logic out_overflow,
    output logic out_accept,
    output logic out_iso,
    output logic [5:0] out_sample_bytes,
    // IN side from serial engine
    input wire logic in_req,
    input wire logic [2:0] in_ep,
    input wire logic in_done,
    output logic [1:0] in_hs,
    output logic [11:0] in_len,
    output logic irq
);
    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] out_cfg_q; // OUT configuration byte
    logic [NUM_IN-1:0] in_iso_q; // Per IN endpoint iso select
    logic [2:0] in_sel_q; // Endpoint seen through count window
    logic [uecb_pkg::EV_W-1:0] stat_q; // Sticky events
    logic [uecb_pkg::EV_W-1:0] en_q; // Event enables
    logic ph_wr_q; // Data phase is a write
    logic ph_act_q; // Data phase pending
    logic [7:0] ph_addr_q; // Latched address
    logic [31:0] rdata_q; // Read data register
    logic [1:0] hs_q; // Registered handshake
    logic [11:0] len_q; // Registered length
    logic wr_stb; // Write data phase
    logic [7:0] cnt_all [NUM_IN]; // All count bytes
    logic [NUM_IN-1:0] cnt_wr; // Per endpoint write
    logic [NUM_IN-1:0] done_v; // Per endpoint IN completion
    logic [7:0] cur_cnt; // Count byte of addressed endpoint
    logic [11:0] len_c; // Length of addressed endpoint
    logic [uecb_pkg::EV_W-1:0] ev; // Event pulses
    logic nak_c; // NAK decision this cycle
    logic ep_ok; // Endpoint number in range
    // Bytes of an IN config block; no block base math uses it [RQ6]
    localparam int BLK_BYTES = uecb_pkg::CFG_BLOCK_BYTES;

    // Decode a word address within the map
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // ************************************************************
    // AHB-Lite address phase capture
    // ************************************************************
    // Slave is zero wait state, so ready is always high
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ph_act_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else if (hready) begin
            ph_act_q <= hsel & htrans[1];
            ph_wr_q <= hsel & htrans[1] & hwrite;
            ph_addr_q <= haddr[7:0];
        end
    end
    assign wr_stb = ph_act_q & ph_wr_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0; // Always OKAY; unmapped reads zero

    // ************************************************************
    // OUT configuration byte
    // ************************************************************
    // Overflow set beats a simultaneous software clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out_cfg_q <= uecb_pkg::OUT_CFG_RST;
        end else begin
            if (wr_stb && is_addr(ph_addr_q, uecb_pkg::OUT_CFG_ADDR)) begin
                out_cfg_q <= hwdata[7:0];
            end
            if (out_overflow) begin
                out_cfg_q[uecb_pkg::OUT_OVF_BIT] <= 1'b1; // Diagnostic only [RQ3] [RQ4]
            end
        end
    end
    // Overflow bit feeds nothing but status [RQ3]
    assign out_accept = out_req & out_cfg_q[uecb_pkg::OUT_EN_BIT]; // [RQ1]
    assign out_iso = out_cfg_q[uecb_pkg::OUT_ISO_BIT]; // [RQ2]
    assign out_sample_bytes = {1'b0, out_cfg_q[uecb_pkg::SWB_MSB:0]} + 6'h01; // [RQ5]

    // ************************************************************
    // IN endpoint iso select and window select
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            in_iso_q <= '0;
            in_sel_q <= 3'h0;
        end else if (wr_stb) begin
            if (is_addr(ph_addr_q, uecb_pkg::IN_CFG_ADDR)) begin
                in_iso_q <= hwdata[NUM_IN-1:0];
            end
            if (is_addr(ph_addr_q, uecb_pkg::IN_SEL_ADDR)) begin
                in_sel_q <= hwdata[2:0];
            end
        end
    end

    // ************************************************************
    // IN endpoint count bytes, one instance each
    // ************************************************************
    // Endpoint numbers 1..NUM_IN map to index 0..NUM_IN-1 [RQ7]
    for (genvar i = 0; i < NUM_IN; i++) begin : g_ep
        assign cnt_wr[i] = wr_stb && is_addr(ph_addr_q, uecb_pkg::IN_CNT_ADDR)
            && (in_sel_q == 3'(i + 1));
        assign done_v[i] = in_done && (in_ep == 3'(i + 1)) && ~nak_c;
        uecb_in_ep u_ep (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .wr_en(cnt_wr[i]),
            .wr_data(hwdata[7:0]),
            .in_done(done_v[i]),
            .cnt_byte(cnt_all[i])
        );
    end

    // ************************************************************
    // IN handshake decision
    // ************************************************************
    always_comb begin
        ep_ok = (in_ep != 3'h0) && (32'(in_ep) <= NUM_IN);
        cur_cnt = 8'h00;
        nak_c = 1'b0;
        if (ep_ok) begin
            cur_cnt = cnt_all[in_ep - 3'h1];
            // Iso never NAKs; empty flag ignored there [RQ9] [RQ11]
            nak_c = cur_cnt[uecb_pkg::EMPTY_BIT] & ~in_iso_q[in_ep - 3'h1];
        end
    end

    uecb_len_calc u_len (
        .iso(ep_ok ? in_iso_q[in_ep - 3'h1] : 1'b0),
        .count(cur_cnt[uecb_pkg::CNT_MSB:0]),
        .swb(out_cfg_q[uecb_pkg::SWB_MSB:0]),
        .len_bytes(len_c)
    );

    // Registered answer one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hs_q <= uecb_pkg::UECB_HS_NONE;
            len_q <= 12'h000;
        end else if (in_req && ep_ok) begin
            hs_q <= nak_c ? uecb_pkg::UECB_HS_NAK : uecb_pkg::UECB_HS_DATA; // [RQ9]
            len_q <= nak_c ? 12'h000 : len_c; // [RQ15]
        end else begin
            hs_q <= uecb_pkg::UECB_HS_NONE;
            len_q <= 12'h000;
        end
    end
    assign in_hs = hs_q;
    assign in_len = len_q;

    // ************************************************************
    // Interrupt status, enable, clear
    // ************************************************************
    assign ev[uecb_pkg::EV_OVF] = out_overflow;
    assign ev[uecb_pkg::EV_IN_DONE] = |done_v;
    assign ev[uecb_pkg::EV_NAK] = in_req & ep_ok & nak_c;
    // New event wins over clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stat_q <= '0;
            en_q <= '0;
        end else begin
            if (wr_stb && is_addr(ph_addr_q, uecb_pkg::IRQ_CLR_ADDR)) begin
                stat_q <= (stat_q & ~hwdata[uecb_pkg::EV_W-1:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
            if (wr_stb && is_addr(ph_addr_q, uecb_pkg::IRQ_EN_ADDR)) begin
                en_q <= hwdata[uecb_pkg::EV_W-1:0];
            end
        end
    end
    assign irq = |(stat_q & en_q);

    // ************************************************************
    // Read data
    // ************************************************************
    // Read mux uses address-phase signals so data lands in data phase
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                uecb_pkg::OUT_CFG_ADDR: rdata_q <= {24'h000000, out_cfg_q};
                uecb_pkg::IN_CFG_ADDR: rdata_q <= 32'(in_iso_q);
                uecb_pkg::IN_CNT_ADDR: begin
                    if (in_sel_q != 3'h0 && 32'(in_sel_q) <= NUM_IN) begin
                        rdata_q <= {24'h000000, cnt_all[in_sel_q - 3'h1]};
                    end else begin
                        rdata_q <= 32'h0000_0000;
                    end
                end
                uecb_pkg::IN_SEL_ADDR: rdata_q <= {29'h00000000, in_sel_q};
                uecb_pkg::IRQ_STAT_ADDR: rdata_q <= {29'h00000000, stat_q};
                uecb_pkg::IRQ_EN_ADDR: rdata_q <= {29'h00000000, en_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign hrdata = rdata_q;
endmodule

// >>> verification/uecb_asserts.sv
// Port checker for the endpoint configuration byte block.
// Assumes a bind onto uecb_top; the shared package is compiled first.
`timescale 1ns/10ps
module uecb_asserts #(
    parameter int NUM_IN = 7
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic out_req,
    input wire logic out_accept,
    input wire logic out_iso,
    input wire logic [5:0] out_sample_bytes,
    input wire logic in_req,
    input wire logic [2:0] in_ep,
    input wire logic [1:0] in_hs
);
    // ************************************************************
    // Port relations, all on sys_clk
    // ************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic take; // Address phase accepted
    logic cfg_wr; // Write aimed at the OUT byte
    assign take = hsel & hready & htrans[1];
    assign cfg_wr = take & hwrite & (haddr[7:0] == uecb_pkg::OUT_CFG_ADDR);
    a_accept_needs_req: assert property (out_accept |-> out_req)
        else $error("OUT accepted with no offer");
    a_width_in_range: assert property (out_sample_bytes inside {[6'd1:6'd32]})
        else $error("Sample width outside one to thirty-two");
    a_cfg_by_write: assert property ($changed({out_iso, out_sample_bytes}) |-> $past(cfg_wr, 2))
        else $error("OUT settings moved without a write");
    a_hs_has_cause: assert property (in_hs != uecb_pkg::UECB_HS_NONE |->
        $past(in_req) && $past(in_ep) != 3'd0 && $past(in_ep) <= NUM_IN)
        else $error("Handshake with no valid token");
    a_hs_answers: assert property (in_req && in_ep != 3'd0 && in_ep <= NUM_IN |=>
        in_hs inside {uecb_pkg::UECB_HS_DATA, uecb_pkg::UECB_HS_NAK})
        else $error("Token left unanswered");
    a_hs_one_cycle: assert property (!in_req |=> in_hs == uecb_pkg::UECB_HS_NONE)
        else $error("Handshake held past one cycle");
    a_rdata_cause: assert property ($changed(hrdata) |-> $past(take & ~hwrite))
        else $error("Read data moved with no read");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("Bus slave stalled or erred");
    c_nak: cover property (in_hs == uecb_pkg::UECB_HS_NAK);
    c_data: cover property (in_hs == uecb_pkg::UECB_HS_DATA);
    c_accept: cover property (out_accept);
endmodule

// >>> verification/uecb_sie_model.sv
// Serial engine stand-in: OUT offers, overflow, IN tokens and IN ends.
// Assumes its tasks are called from one bench process only.
`timescale 1ns/10ps
module uecb_sie_model (
    input wire logic sys_clk,
    output logic out_req,
    output logic out_overflow,
    output logic in_req,
    output logic [2:0] in_ep,
    output logic in_done,
    input wire logic [1:0] in_hs,
    input wire logic [11:0] in_len
);
    // ************************************************************
    // Strobes change just after an edge
    // ************************************************************
    initial {out_req, out_overflow, in_req, in_ep, in_done} = '0;
    // Level offer, looked at once settled
    task automatic offer(input logic v);
        @(posedge sys_clk);
        out_req <= v;
        #1;
    endtask
    // Token pulse; answer read just after the taking edge
    task automatic token(input logic [2:0] ep, output logic [1:0] hs, output logic [11:0] len);
        @(posedge sys_clk);
        in_ep <= ep;
        in_req <= 1'b1;
        @(posedge sys_clk);
        in_req <= 1'b0;
        #1;
        hs = in_hs;
        len = in_len;
    endtask
    // One-cycle pulse: IN end if sel, else overflow
    task automatic pulse(input logic sel);
        @(posedge sys_clk);
        if (sel) in_done <= 1'b1;
        else out_overflow <= 1'b1;
        @(posedge sys_clk);
        {in_done, out_overflow} <= 2'b00;
    endtask
endmodule

// >>> verification/test_usb_endpoint_config_bytes.sv
// Self-checking bench: bus master, reference model and port compares.
// Assumes the package, design, checker and serial engine model compiled first.
`timescale 1ns/10ps
module test_usb_endpoint_config_bytes;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic hreadyout, hresp, out_req, out_overflow, out_accept, out_iso, in_req, in_done, irq;
    logic [5:0] out_sample_bytes;
    logic [2:0] in_ep;
    logic [1:0] in_hs, hs;
    logic [11:0] in_len, len;
    logic [31:0] seed = 32'h2E6C33B2; // Fixed xorshift start
    int n_fail = 0, samples_checked = 0, cyc = 0, c, cfg_m, stat_m = 0, iso_m;
    always #5 sys_clk = ~sys_clk;
    uecb_top u_uecb_top (.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .out_req, .out_overflow,
        .out_accept, .out_iso, .out_sample_bytes, .in_req, .in_ep, .in_done, .in_hs,
        .in_len, .irq);
    uecb_sie_model u_uecb_sie_model (.sys_clk, .out_req, .out_overflow, .in_req, .in_ep,
        .in_done, .in_hs, .in_len);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Single word transfer; waits on ready at both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'h2, w};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
        // Let the write land before any caller looks at side effects
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out();
        $display("Compared %0d, mismatched %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard, far above the expected run
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 8'(i * 4), 0);
            chk("reset_read", 0, q);
        end
        $display("Test reset values done");
        for (int i = 0; i < 6; i++) begin
            cfg_m = (i == 0) ? 8'h00 : (i == 1) ? 8'hDF : rnd() & 8'hDF;
            bus(1'b1, uecb_pkg::OUT_CFG_ADDR, cfg_m);
            u_uecb_sie_model.offer(i[0]);
            chk("out_accept", cfg_m[7] & i[0], out_accept);
            chk("out_iso", cfg_m[6], out_iso);
            chk("out_sample_bytes", cfg_m[4:0] + 1, out_sample_bytes);
        end
        $display("Test OUT settings done");
        bus(1'b1, uecb_pkg::IRQ_EN_ADDR, 1);
        u_uecb_sie_model.pulse(1'b0);
        cfg_m |= 8'h20;
        bus(1'b0, uecb_pkg::OUT_CFG_ADDR, 0);
        chk("ovf_set", cfg_m, q);
        chk("irq_on", 1, irq);
        bus(1'b1, uecb_pkg::OUT_CFG_ADDR, cfg_m);
        bus(1'b0, uecb_pkg::OUT_CFG_ADDR, 0);
        chk("ovf_kept", cfg_m, q);
        cfg_m = 8'h80 | (rnd() & 8'h1F);
        bus(1'b1, uecb_pkg::OUT_CFG_ADDR, cfg_m);
        bus(1'b0, uecb_pkg::OUT_CFG_ADDR, 0);
        chk("ovf_cleared", cfg_m, q);
        bus(1'b1, uecb_pkg::IRQ_CLR_ADDR, 1);
        chk("irq_off", 0, irq);
        bus(1'b1, uecb_pkg::IRQ_EN_ADDR, 0);
        u_uecb_sie_model.pulse(1'b0);
        bus(1'b0, uecb_pkg::IRQ_STAT_ADDR, 0);
        chk("stat_masked", 1, q);
        chk("irq_masked", 0, irq);
        bus(1'b1, uecb_pkg::OUT_CFG_ADDR, cfg_m);
        $display("Test overflow done");
        stat_m = 1;
        iso_m = rnd() & 8'h7F;
        bus(1'b1, uecb_pkg::IN_CFG_ADDR, iso_m);
        for (int ep = 1; ep <= 7; ep++) begin
            c = rnd() & 8'h7F;
            bus(1'b1, uecb_pkg::IN_SEL_ADDR, ep);
            bus(1'b1, uecb_pkg::IN_CNT_ADDR, c);
            bus(1'b0, uecb_pkg::IN_CNT_ADDR, 0);
            chk("count", c, q);
            u_uecb_sie_model.token(3'(ep), hs, len);
            chk("hs_full", 1, hs);
            chk("len", iso_m[ep - 1] ? c * (cfg_m[4:0] + 1) : c, len);
            u_uecb_sie_model.pulse(1'b1);
            bus(1'b0, uecb_pkg::IN_CNT_ADDR, 0);
            chk("empty_set", c | 8'h80, q);
            u_uecb_sie_model.token(3'(ep), hs, len);
            chk("hs_empty", iso_m[ep - 1] ? 1 : 2, hs);
            stat_m |= iso_m[ep - 1] ? 2 : 6;
            bus(1'b1, uecb_pkg::IN_CNT_ADDR, c);
            u_uecb_sie_model.token(3'(ep), hs, len);
            chk("hs_refill", 1, hs);
        end
        u_uecb_sie_model.token(3'd0, hs, len);
        chk("hs_ep0", 0, hs);
        bus(1'b0, uecb_pkg::IRQ_STAT_ADDR, 0);
        chk("status", stat_m, q);
        bus(1'b1, uecb_pkg::IRQ_EN_ADDR, 6);
        chk("irq_in", 1, irq);
        bus(1'b1, uecb_pkg::IRQ_CLR_ADDR, 7);
        chk("irq_cleared", 0, irq);
        $display("Test IN endpoints done");
        close_out();
    end
endmodule
bind uecb_top uecb_asserts #(.NUM_IN(NUM_IN)) u_uecb_asserts (.sys_clk, .sys_rst, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .out_req, .out_accept,
    .out_iso, .out_sample_bytes, .in_req, .in_ep, .in_hs);
